// ---- hdl/tbm_pkg.sv ----
// Purpose : shared constants for the tuner bias mode control core
// Assumes : 50 MHz system clock
// Notes   : all counts derived from times in their own units
package tbm_pkg;
   // =====================================================
   // channel and code widths
   localparam int          TBM_CHANNELS       = 6;
   localparam int          TBM_DAC_W          = 7;
   localparam int          TBM_BOOST_W        = 4;
   localparam int          TBM_MV_W           = 15;
   // =====================================================
   // analog scaling
   localparam int          TBM_DAC_STEP_MV    = 188;
   localparam int          TBM_BOOST_BASE_V   = 13;
   localparam int          TBM_HEADROOM_V     = 2;
   // =====================================================
   // reset values
   localparam logic [3:0]  TBM_BOOST_RST      = 4'hb;
   localparam logic [5:0]  TBM_EN_RST         = 6'h00;
   localparam logic [6:0]  TBM_DAC_RST        = 7'h00;
   // =====================================================
   // power-state field encodings
   localparam logic [1:0]  TBM_PS_ACTIVE      = 2'h0;
   localparam logic [1:0]  TBM_PS_STARTUP     = 2'h1;
   localparam logic [1:0]  TBM_PS_LOWPWR      = 2'h2;
   // =====================================================
   // timing
   localparam int          TBM_CLK_MHZ        = 50;
   localparam int          TBM_SD_TO_ACT_US   = 300;
   localparam int          TBM_STARTUP_CYC    =
      TBM_SD_TO_ACT_US * TBM_CLK_MHZ;
   localparam int          TBM_CNT_W          = 15;
   // =====================================================
   // three-wire frame
   localparam logic [5:0]  TBM_LEN_SHORT      = 6'h1e;
   localparam logic [5:0]  TBM_LEN_LONG       = 6'h20;
   localparam int          TBM_ADDR_W         = 5;
   localparam int          TBM_DATA_W         = 16;
   // =====================================================
   // protocol kinds
   typedef enum logic [1:0] {
      TBM_PROTO_NONE,
      TBM_PROTO_RFFE,
      TBM_PROTO_SW30,
      TBM_PROTO_SW32
   } tbm_proto_t;
endpackage : tbm_pkg

// ---- hdl/tbm_core.sv ----
// Purpose : power-state sequencer, boost level, channel enables, and
//           per-frame serial protocol detection for six-channel bias
// Assumes : decoded register writes arrive as same-clock strobes;
//           serial pins are asynchronous and synchronised here
// Notes   : voltages are reported in millivolts for the analog side
`timescale 1ns/1ns
module tbm_core
   import tbm_pkg::*;
(
   // clock and reset
   input  wire logic                   clock_in,
   input  wire logic                   sys_rst_in,
   // supplies and analog comparator
   input  wire logic                   io_supply_in,
   input  wire logic                   rail_below_ref_in,
   // decoded register writes
   input  wire logic                   pwr_wr_in,
   input  wire logic [1:0]             power_state_command_in,
   input  wire logic                   boost_wr_in,
   input  wire logic [TBM_BOOST_W-1:0] boost_code_in,
   input  wire logic                   en_wr_in,
   input  wire logic [TBM_CHANNELS-1:0] chan_en_in,
   input  wire logic                   dac_wr_in,
   input  wire logic [2:0]             dac_sel_in,
   input  wire logic [TBM_DAC_W-1:0]   dac_code_in,
   // serial pins
   input  wire logic                   ser_clk_in,
   input  wire logic                   ser_cs_in,
   input  wire logic                   ser_data_in,
   // power state view
   output logic [1:0]                  power_state_out,
   output logic                        serial_on_out,
   output logic                        boost_on_out,
   output logic                        boost_switch_out,
   output logic [TBM_MV_W-1:0]         rail_target_mv_out,
   // channel outputs
   output logic [TBM_CHANNELS-1:0]     chan_drive_out,
   output logic [TBM_CHANNELS*TBM_MV_W-1:0] chan_mv_out,
   // frame detection
   output logic                        frame_valid_out,
   output tbm_proto_t                  frame_proto_out,
   output logic [TBM_ADDR_W-1:0]       frame_addr_out,
   output logic [TBM_DATA_W-1:0]       frame_data_out
);
   // =====================================================
   // power-state machine types
   typedef enum logic [1:0] {
      ST_SHUTDOWN,
      ST_STARTUP,
      ST_ACTIVE,
      ST_LOWPWR
   } tbm_state_t;

   tbm_state_t             state_reg;           // current state
   tbm_state_t             state_next;          // next state
   logic [TBM_CNT_W-1:0]   su_cnt_reg;          // startup timer
   logic [TBM_CNT_W-1:0]   su_cnt_next;
   logic [1:0]             io_sync_reg;         // io supply sync
   logic [2:0]             sclk_sync_reg;       // serial clock sync
   logic [2:0]             cs_sync_reg;         // chip select sync
   logic [1:0]             sdat_sync_reg;       // serial data sync
   logic [TBM_BOOST_W-1:0] boost_reg;           // boost level code
   logic [TBM_CHANNELS-1:0] en_reg;             // channel enables
   logic [TBM_DAC_W-1:0]   dac_reg [TBM_CHANNELS]; // channel codes
   logic [31:0]            shift_reg;           // frame shifter
   logic [5:0]             bits_reg;            // rising edge count
   logic                   dropped_reg;         // frame over length
   logic                   sw_clr;              // registers cleared
   logic                   io_high;             // synced io level
   logic                   sclk_rise;           // serial clock rise
   logic                   cs_fall;             // chip select fall
   logic                   cs_rise;             // chip select rise
   logic                   cs_high;             // synced cs level
   logic                   len_ok;              // 30 or 32 edges
   logic                   is_long;             // 32-bit frame
   logic                   sw_active;           // serial enabled

   // =====================================================
   // synchronisers: first stage read only by the second
   // data and clock both pass two stages, so a bit is taken from
   // the same depth as the clock edge that marks it; the third
   // clock and select stages only feed the edge detectors
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         io_sync_reg   <= 2'h0;
         sclk_sync_reg <= 3'h0;
         cs_sync_reg   <= 3'h0;
         sdat_sync_reg <= 2'h0;
      end
      else
      begin
         io_sync_reg   <= {io_sync_reg[0], io_supply_in};
         sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk_in};
         cs_sync_reg   <= {cs_sync_reg[1:0], ser_cs_in};
         sdat_sync_reg <= {sdat_sync_reg[0], ser_data_in};
      end
   end

   // edge detection on the second and third stages only
   assign io_high   = io_sync_reg[1];
   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign cs_high   = cs_sync_reg[1];
   assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
   assign cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];

   // =====================================================
   // power-state next-state logic
   always_comb
   begin
      state_next  = state_reg;
      su_cnt_next = su_cnt_reg;
      if (!io_high)
      begin
         // low io supply wins from any state; re-arm only on low
         state_next  = ST_SHUTDOWN;
         su_cnt_next = '0;
      end
      else
      begin
         case (state_reg)
            ST_SHUTDOWN:
            begin
               state_next  = ST_STARTUP;
               su_cnt_next = '0;
            end
            ST_STARTUP:
            begin
               // fixed settle time, one cycle inside the budget
               // the io synchroniser adds its own edges on top, so
               // the whole walk from the io supply rising runs past the limit
               if (su_cnt_reg == TBM_CNT_W'(TBM_STARTUP_CYC - 2))
                  state_next = ST_ACTIVE;
               else
                  su_cnt_next = su_cnt_reg + 1'b1;
            end
            ST_ACTIVE:
            begin
               if (pwr_wr_in &&
                   power_state_command_in == TBM_PS_STARTUP)
               begin
                  state_next  = ST_STARTUP;
                  su_cnt_next = '0;
               end
               else if (pwr_wr_in &&
                        power_state_command_in == TBM_PS_LOWPWR)
                  state_next = ST_LOWPWR;
            end
            ST_LOWPWR:
            begin
               if (pwr_wr_in &&
                   power_state_command_in == TBM_PS_STARTUP)
               begin
                  state_next  = ST_STARTUP;
                  su_cnt_next = '0;
               end
               else if (pwr_wr_in &&
                        power_state_command_in == TBM_PS_ACTIVE)
                  state_next = ST_ACTIVE;
            end
            default:
               state_next = ST_SHUTDOWN;
         endcase
      end
   end

   // state and timer registers
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_reg  <= ST_SHUTDOWN;
         su_cnt_reg <= '0;
      end
      else
      begin
         state_reg  <= state_next;
         su_cnt_reg <= su_cnt_next;
      end
   end

   // registers lose content in shutdown and reload in startup
   assign sw_clr    = (state_reg == ST_SHUTDOWN) ||
                      (state_reg == ST_STARTUP);
   // serial logic is held reset while io supply is low
   assign sw_active = (state_reg != ST_SHUTDOWN);

   // =====================================================
   // configuration registers
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         boost_reg <= TBM_BOOST_RST;
         en_reg    <= TBM_EN_RST;
      end
      else if (sw_clr)
      begin
         boost_reg <= TBM_BOOST_RST;
         en_reg    <= TBM_EN_RST;
      end
      else
      begin
         // writes land in active and low power; low power retains
         // a write in the same cycle as a restart command lands,
         // then the restart clears it again on the following edge
         if (boost_wr_in)
            boost_reg <= boost_code_in;
         if (en_wr_in)
            en_reg <= chan_en_in;
      end
   end

   // =====================================================
   // per-channel code registers and level mapping
   genvar g;
   generate
      for (g = 0; g < TBM_CHANNELS; g++)
      begin : g_chan
         always_ff @(posedge clock_in or posedge sys_rst_in)
         begin
            if (sys_rst_in)
               dac_reg[g] <= TBM_DAC_RST;
            else if (sw_clr)
               dac_reg[g] <= TBM_DAC_RST;
            else if (dac_wr_in && dac_sel_in == 3'(g))
               dac_reg[g] <= dac_code_in;
         end
         // drive only in active and only when enabled
         assign chan_drive_out[g] = (state_reg == ST_ACTIVE) &&
                                    en_reg[g];
         assign chan_mv_out[g*TBM_MV_W +: TBM_MV_W] =
            TBM_MV_W'(dac_reg[g] * TBM_DAC_STEP_MV);
      end
   endgenerate

   // =====================================================
   // boost enable and hysteretic switching
   // the comparator is a same-clock signal from the analog side,
   // so it is used here without a synchroniser
   assign boost_on_out     = (state_reg == ST_STARTUP) ||
                             (state_reg == ST_ACTIVE);
   assign boost_switch_out = boost_on_out &&
                             rail_below_ref_in;
   assign rail_target_mv_out =
      TBM_MV_W'((TBM_BOOST_BASE_V + boost_reg) * 1000);
   assign serial_on_out    = sw_active;

   // reported power-state field; low power code is distinct
   always_comb
   begin
      case (state_reg)
         ST_ACTIVE: power_state_out = TBM_PS_ACTIVE;
         ST_LOWPWR: power_state_out = TBM_PS_LOWPWR;
         default:   power_state_out = TBM_PS_STARTUP;
      endcase
   end

   // =====================================================
   // three-wire frame capture
   // the count saturates and marks the frame dropped, so a long
   // burst can never wrap round to a legal length
   assign len_ok  = (bits_reg == TBM_LEN_SHORT) ||
                    (bits_reg == TBM_LEN_LONG);
   assign is_long = (bits_reg == TBM_LEN_LONG);

   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         shift_reg   <= '0;
         bits_reg    <= '0;
         dropped_reg <= 1'b0;
      end
      else if (!sw_active || cs_rise)
      begin
         shift_reg   <= '0;
         bits_reg    <= '0;
         dropped_reg <= 1'b0;
      end
      else if (cs_high && sclk_rise)
      begin
         // msb arrives first and shifts toward the top
         shift_reg <= {shift_reg[30:0], sdat_sync_reg[1]};
         if (bits_reg == 6'h3f)
            dropped_reg <= 1'b1;
         else
            bits_reg <= bits_reg + 1'b1;
      end
   end

   // =====================================================
   // frame result, committed on chip select fall
   // a frame under way when the io supply drops is lost, since the
   // shifter is held clear while the serial side is off
   always_ff @(posedge clock_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         frame_valid_out <= 1'b0;
         frame_proto_out <= TBM_PROTO_NONE;
         frame_addr_out  <= '0;
         frame_data_out  <= '0;
      end
      else
      begin
         frame_valid_out <= 1'b0;
         if (sw_active && cs_fall && len_ok && !dropped_reg)
         begin
            frame_valid_out <= 1'b1;
            frame_proto_out <= is_long ? TBM_PROTO_SW32
                                       : TBM_PROTO_SW30;
            frame_addr_out  <= shift_reg[20:16];
            frame_data_out  <= shift_reg[15:0];
         end
         else if (sw_active && !cs_high && sclk_rise)
            // clock with cs low is bus traffic of the other kind
            frame_proto_out <= TBM_PROTO_RFFE;
      end
   end

endmodule : tbm_core

// ---- test/tbm_core_sva.sv ----
// Purpose : port assertions for the bias mode control core
// Assumes : one clock domain, asynchronous active-high reset
// Notes   : bound to every tbm_core instance below
`timescale 1ns/1ns
module tbm_core_sva
   import tbm_pkg::*;
(
   // clock, reset and stimulus
   input  wire logic                    clock_in,
   input  wire logic                    sys_rst_in,
   input  wire logic                    io_supply_in,
   input  wire logic                    rail_below_ref_in,
   input  wire logic                    pwr_wr_in,
   input  wire logic [1:0]              power_state_command_in,
   input  wire logic                    en_wr_in,
   input  wire logic [TBM_CHANNELS-1:0] chan_en_in,
   // observed outputs
   input  wire logic [1:0]              power_state_out,
   input  wire logic                    serial_on_out,
   input  wire logic                    boost_on_out,
   input  wire logic                    boost_switch_out,
   input  wire logic [TBM_MV_W-1:0]     rail_target_mv_out,
   input  wire logic [TBM_CHANNELS-1:0] chan_drive_out,
   input  wire logic                    frame_valid_out,
   input  tbm_proto_t                   frame_proto_out
);
   // ==========================================================
   // helper: cycles held in the 01 view with the io supply up
   localparam int ST_MAX = 15003; // 300 us plus io synchroniser
   logic [TBM_CNT_W-1:0] st_cnt_reg;
   always_ff @(posedge clock_in or posedge sys_rst_in)
      if (sys_rst_in)
         st_cnt_reg <= '0;
      else if (power_state_out == TBM_PS_STARTUP && io_supply_in)
         st_cnt_reg <= st_cnt_reg + 1'b1;
      else
         st_cnt_reg <= '0;
   // ==========================================================
   // assertions
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   property p_sw; boost_switch_out == (boost_on_out & rail_below_ref_in);
   endproperty
   a_sw: assert property (p_sw)
      else $error("boost switching does not follow comparator");
   property p_off; power_state_out != TBM_PS_ACTIVE |-> chan_drive_out == '0;
   endproperty
   a_off: assert property (p_off)
      else $error("channel driven outside active");
   property p_lp; power_state_out == TBM_PS_LOWPWR |->
      !boost_on_out && serial_on_out; endproperty
   a_lp: assert property (p_lp)
      else $error("low power view wrong");
   property p_io; !io_supply_in [*4] |=>
      power_state_out == TBM_PS_STARTUP && !serial_on_out; endproperty
   a_io: assert property (p_io)
      else $error("io supply low did not shut down");
   property p_lpc; pwr_wr_in && power_state_command_in == TBM_PS_LOWPWR &&
      power_state_out == TBM_PS_ACTIVE |=> power_state_out == TBM_PS_LOWPWR;
   endproperty
   a_lpc: assert property (p_lpc)
      else $error("low power command not taken");
   property p_act; pwr_wr_in && power_state_command_in == TBM_PS_ACTIVE &&
      power_state_out == TBM_PS_LOWPWR |=> power_state_out == TBM_PS_ACTIVE
      && boost_on_out; endproperty
   a_act: assert property (p_act)
      else $error("wake command not taken");
   property p_rst; pwr_wr_in && power_state_command_in == TBM_PS_STARTUP &&
      power_state_out != TBM_PS_STARTUP |=> power_state_out ==
      TBM_PS_STARTUP ##2 rail_target_mv_out == 15'd24000; endproperty
   a_rst: assert property (p_rst)
      else $error("restart command did not reset");
   property p_en; en_wr_in && power_state_out == TBM_PS_ACTIVE |=>
      chan_drive_out == $past(chan_en_in); endproperty
   a_en: assert property (p_en)
      else $error("enable write not applied");
   property p_st; st_cnt_reg < ST_MAX; endproperty
   a_st: assert property (p_st)
      else $error("startup too long");
   property p_fr; frame_valid_out |->
      frame_proto_out inside {TBM_PROTO_SW30, TBM_PROTO_SW32}; endproperty
   a_fr: assert property (p_fr)
      else $error("frame pulse with wrong kind");
endmodule : tbm_core_sva
bind tbm_core tbm_core_sva u_sva (.clock_in, .sys_rst_in, .io_supply_in,
   .rail_below_ref_in, .pwr_wr_in, .power_state_command_in, .en_wr_in,
   .chan_en_in, .power_state_out, .serial_on_out, .boost_on_out,
   .boost_switch_out, .rail_target_mv_out, .chan_drive_out,
   .frame_valid_out, .frame_proto_out);

// ---- test/tbm_host_model.sv ----
// Purpose : three-wire serial host for the core's serial pins
// Assumes : levels change on falling system clock edges
// Notes   : clock idles low between frames; data toggles once released
`timescale 1ns/1ns
module tbm_host_model
(
   // timing reference
   input  wire logic clock_in,
   // serial pins
   output logic      ser_clk_out,
   output logic      ser_cs_out,
   output logic      ser_data_out
);
   // idle bus: select low, clock still
   initial
   begin
      ser_clk_out  = 1'b0;
      ser_cs_out   = 1'b0;
      ser_data_out = 1'b0;
   end
   // one frame of len bits, three steps of half system clocks per bit
   task automatic send(input logic [31:0] bits, input int len,
                       input int half, input logic cs);
      repeat (half) @(negedge clock_in);
      ser_cs_out = cs;
      for (int i = len - 1; i >= 0; i--)
      begin
         repeat (half) @(negedge clock_in);
         // over-long test frames reuse the low bits at their head
         ser_data_out = bits[i % 32];
         repeat (half) @(negedge clock_in);
         ser_clk_out = 1'b1;
         repeat (half) @(negedge clock_in);
         ser_clk_out = 1'b0;
         ser_data_out = ~ser_data_out;
      end
      repeat (half) @(negedge clock_in);
      ser_cs_out = 1'b0;
   endtask : send
endmodule : tbm_host_model

// ---- test/tb_tuner_bias_mode_control.sv ----
// Purpose : self-checking bench for the bias mode control core
// Assumes : host model drives serial pins, bench drives the rest
// Notes   : inputs change on the falling clock edge
`timescale 1ns/1ns
module tb_tuner_bias_mode_control;
   import tbm_pkg::*;
   // ==========================================================
   // stimulus and results
   logic clock_in, sys_rst_in, io_supply_in, rail_below_ref_in;
   logic pwr_wr_in, boost_wr_in, en_wr_in, dac_wr_in;
   logic ser_clk, ser_cs, ser_data, serial_on_out, boost_on_out;
   logic boost_switch_out, frame_valid_out;
   logic [1:0]  power_state_command_in, power_state_out;
   logic [3:0]  boost_code_in;
   logic [5:0]  chan_en_in, chan_drive_out, en_exp;
   logic [2:0]  dac_sel_in;
   logic [6:0]  dac_code_in;
   logic [14:0] rail_target_mv_out;
   logic [89:0] chan_mv_out, mv_exp;
   logic [4:0]  frame_addr_out;
   logic [15:0] frame_data_out;
   logic [31:0] bits;
   tbm_proto_t  frame_proto_out;
   logic [22:0] frame_q[$];     // expected frames, oldest first
   int          lens[5] = '{32, 30, 31, 33, 29};
   int          n_fail = 0;
   int          cmp_count = 0;
   tbm_core dut (.clock_in, .sys_rst_in, .io_supply_in, .rail_below_ref_in,
      .pwr_wr_in, .power_state_command_in, .boost_wr_in, .boost_code_in,
      .en_wr_in, .chan_en_in, .dac_wr_in, .dac_sel_in, .dac_code_in,
      .ser_clk_in(ser_clk), .ser_cs_in(ser_cs), .ser_data_in(ser_data),
      .power_state_out, .serial_on_out, .boost_on_out, .boost_switch_out,
      .rail_target_mv_out, .chan_drive_out, .chan_mv_out, .frame_valid_out,
      .frame_proto_out, .frame_addr_out, .frame_data_out);
   tbm_host_model host (.clock_in, .ser_clk_out(ser_clk),
      .ser_cs_out(ser_cs), .ser_data_out(ser_data));
   always #10 clock_in = ~clock_in;
   // ==========================================================
   // tasks
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one-cycle strobe: 0 power, 1 boost, 2 enable, 3 channel code
   task automatic wr(input int k, input logic [6:0] v, input logic [2:0] s);
      @(negedge clock_in);
      power_state_command_in = v[1:0];
      boost_code_in = v[3:0];
      chan_en_in = v[5:0];
      dac_code_in = v;
      dac_sel_in = s;
      {pwr_wr_in, boost_wr_in, en_wr_in, dac_wr_in} = 4'h8 >> k;
      @(negedge clock_in);
      {pwr_wr_in, boost_wr_in, en_wr_in, dac_wr_in} = 4'h0;
   endtask : wr
   // startup view, then bounded wait for active
   task automatic up();
      int n;
      n = 0;
      @(negedge clock_in);
      chk({power_state_out, chan_drive_out}, {TBM_PS_STARTUP, 6'h0});
      chk(rail_target_mv_out, 24000);
      while (power_state_out !== TBM_PS_ACTIVE && n < 16000)
      begin
         @(negedge clock_in);
         n++;
      end
      chk(n < 15003, 1);
      chk({chan_drive_out, chan_mv_out}, 0);
   endtask : up
   task automatic end_of_test();
      $display("mismatches %0d, comparisons %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   // each frame pulse takes the oldest note off the queue
   always @(negedge clock_in)
      if (frame_valid_out === 1'b1)
      begin
         if (frame_q.size() == 0)
            chk(1, 0);
         else
            chk({frame_proto_out, frame_addr_out, frame_data_out},
                frame_q.pop_front());
      end
   // watchdog well beyond the planned run
   initial
   begin
      #1600000;
      n_fail++;
      end_of_test();
   end
   // ==========================================================
   // main sequence
   initial
   begin
      clock_in = 1'b0;
      sys_rst_in = 1'b1;
      io_supply_in = 1'b1;
      rail_below_ref_in = 1'b0;
      {pwr_wr_in, boost_wr_in, en_wr_in, dac_wr_in} = 4'h0;
      {power_state_command_in, boost_code_in, chan_en_in} = 12'h000;
      {dac_sel_in, dac_code_in} = 10'h000;
      mv_exp = '0;
      void'($urandom(2));
      repeat (12) @(negedge clock_in);
      sys_rst_in = 1'b0;
      up();
      // every boost code, ending at the top for rail headroom
      for (int c = 0; c < 16; c++)
      begin
         wr(1, 7'(c), 3'h0);
         chk(rail_target_mv_out, (13 + c) * 1000);
      end
      // channel codes, range ends first, all still off
      for (int g = 0; g < 6; g++)
      begin
         bits[6:0] = (g == 0) ? 7'h7f : (g == 1) ? 7'h00 : 7'($urandom);
         wr(3, bits[6:0], 3'(g));
         mv_exp[g*15 +: 15] = 15'(bits[6:0] * 188);
      end
      chk({chan_mv_out, chan_drive_out}, {mv_exp, 6'h0});
      // single enables, then random masks
      for (int g = 0; g < 8; g++)
      begin
         en_exp = (g < 6) ? 6'h01 << g : 6'($urandom);
         wr(2, {1'b0, en_exp}, 3'h0);
         chk(chan_drive_out, en_exp);
      end
      rail_below_ref_in = 1'b1;
      @(negedge clock_in);
      chk(boost_switch_out, 1);
      wr(0, {5'h0, TBM_PS_LOWPWR}, 3'h0);
      chk({power_state_out, boost_on_out, serial_on_out, boost_switch_out,
           chan_drive_out}, {TBM_PS_LOWPWR, 3'b010, 6'h0});
      wr(0, {5'h0, TBM_PS_ACTIVE}, 3'h0);
      chk({power_state_out, chan_drive_out}, {TBM_PS_ACTIVE, en_exp});
      rail_below_ref_in = 1'b0;
      // fast long, slow short, then three wrong lengths
      for (int f = 0; f < 5; f++)
      begin
         bits = $urandom;
         if (f < 2)
            frame_q.push_back({f ? TBM_PROTO_SW30 : TBM_PROTO_SW32, bits[20:0]});
         host.send(bits, lens[f], 3 + 2 * f, 1'b1);
      end
      host.send(bits, 4, 3, 1'b0);
      repeat (10) @(negedge clock_in);
      chk({frame_proto_out, 8'(frame_q.size())}, {TBM_PROTO_RFFE, 8'h0});
      wr(0, {5'h0, TBM_PS_STARTUP}, 3'h0);
      up();
      // io supply drop: everything off, writes and frames refused
      wr(2, 7'h3f, 3'h0);
      wr(3, 7'h7f, 3'h5);
      io_supply_in = 1'b0;
      repeat (4) @(negedge clock_in);
      wr(2, 7'h3f, 3'h0);
      host.send(bits, 32, 3, 1'b1);
      chk({power_state_out, serial_on_out, boost_on_out, chan_drive_out},
          {TBM_PS_STARTUP, 8'h0});
      io_supply_in = 1'b1;
      up();
      frame_q.push_back({TBM_PROTO_SW32, bits[20:0]});
      host.send(bits, 32, 3, 1'b1);
      repeat (10) @(negedge clock_in);
      chk(frame_q.size(), 0);
      end_of_test();
   end
endmodule : tb_tuner_bias_mode_control
